// File: src/octrx_cfg.svh
`ifndef OCTRX_CFG_SVH
`define OCTRX_CFG_SVH

// Register byte offsets
`define OCTRX_CTRL_OFS        8'h00
`define OCTRX_STATUS_OFS      8'h04
`define OCTRX_A_STORE_OFS     8'h08
`define OCTRX_B_STORE_OFS     8'h0c
`define OCTRX_PINS_OFS        8'h10
`define OCTRX_COUNT_OFS       8'h14

// Control register fields
`define OCTRX_CTRL_OE_N_BIT   0
`define OCTRX_CTRL_DIR_BIT    1
`define OCTRX_CTRL_ASRC_BIT   2
`define OCTRX_CTRL_BSRC_BIT   3
`define OCTRX_CTRL_WIDTH      4
`define OCTRX_CTRL_RESET      4'h1

// Status register fields
`define OCTRX_STAT_A_CAP_BIT  0
`define OCTRX_STAT_B_CAP_BIT  1
`define OCTRX_STAT_A_OE_BIT   2
`define OCTRX_STAT_B_OE_BIT   3

// Pins register fields
`define OCTRX_PINS_A_LSB      0
`define OCTRX_PINS_B_LSB      8

// Count register fields
`define OCTRX_CNT_A_LSB       0
`define OCTRX_CNT_B_LSB       8
`define OCTRX_CNT_WIDTH       8

// Decoded address width
`define OCTRX_ADDR_BITS       8

// Storage register value after hresetn
`define OCTRX_STORE_RESET     8'h00

`endif

// File: src/octrx_pkg.sv
package octrx_pkg;

   typedef enum logic [1:0] {
      OCTRX_PH_IDLE  = 2'b00,
      OCTRX_PH_WRITE = 2'b01,
      OCTRX_PH_READ  = 2'b11
   } octrx_phase_t;

   typedef struct packed {
      logic b_en;
      logic a_en;
   } octrx_drive_t;

endpackage : octrx_pkg

// File: src/octrx_capture.sv
`timescale 1ns/1ns
`include "octrx_cfg.svh"

module octrx_capture #(
   parameter int WIDTH = 8
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             capture_clock,
   input  wire logic [WIDTH-1:0] bus_in,
   output logic      [WIDTH-1:0] stored,
   output logic                  captured
);

   logic             clk_prev_r;
   logic             clk_prev_nxt;
   logic [WIDTH-1:0] data_r;
   logic [WIDTH-1:0] data_nxt;
   logic             cap_r;
   logic             cap_nxt;

   // Rising edge of the capture clock loads the bus, regardless of drive state
   always_comb begin
      clk_prev_nxt = capture_clock;
      cap_nxt      = capture_clock & ~clk_prev_r;
      data_nxt     = data_r;
      if (capture_clock && !clk_prev_r) begin
         data_nxt = bus_in;
      end
   end

   // Hold contents while no edge arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_prev_r <= 1'b0;
         data_r     <= WIDTH'(`OCTRX_STORE_RESET);
         cap_r      <= 1'b0;
      end else begin
         clk_prev_r <= clk_prev_nxt;
         data_r     <= data_nxt;
         cap_r      <= cap_nxt;
      end
   end

   assign stored   = data_r;
   assign captured = cap_r;

endmodule : octrx_capture

// File: src/octrx_top.sv
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "octrx_cfg.svh"

module octrx_top #(
   parameter int WIDTH = 8
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [31:0]       hrdata,
   input  wire logic              a_capture_clock,
   input  wire logic              b_capture_clock,
   input  wire logic [WIDTH-1:0]  a_bus_in,
   output logic      [WIDTH-1:0]  a_bus_out,
   output logic                   a_bus_oe,
   input  wire logic [WIDTH-1:0]  b_bus_in,
   output logic      [WIDTH-1:0]  b_bus_out,
   output logic                   b_bus_oe
);

   localparam int AW = `OCTRX_ADDR_BITS;
   localparam int CW = `OCTRX_CTRL_WIDTH;
   localparam int NW = `OCTRX_CNT_WIDTH;

   // Port drive decode, shared by next-state and status logic
   function automatic octrx_pkg::octrx_drive_t drive_decode(input logic oe_n,
                                                           input logic dir);
      octrx_pkg::octrx_drive_t d;
      d.a_en = ~oe_n & ~dir;
      d.b_en = ~oe_n & dir;
      return d;
   endfunction : drive_decode

   // Width-safe placement of a narrow field into a bus word
   function automatic logic [31:0] place(input logic [31:0] value, input int lsb);
      return value << lsb;
   endfunction : place

   logic [WIDTH-1:0]          a_stored;
   logic [WIDTH-1:0]          b_stored;
   logic                      a_captured;
   logic                      b_captured;

   // Capture clocks are sampled on hclk: each needs a low sample between two edges
   octrx_capture #(
      .WIDTH (WIDTH)
   ) u_a_store (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .capture_clock (a_capture_clock),
      .bus_in        (a_bus_in),
      .stored        (a_stored),
      .captured      (a_captured)
   );

   octrx_capture #(
      .WIDTH (WIDTH)
   ) u_b_store (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .capture_clock (b_capture_clock),
      .bus_in        (b_bus_in),
      .stored        (b_stored),
      .captured      (b_captured)
   );

   // Bus phase tracking
   // Only NONSEQ or SEQ with hready opens a transfer; hsize is ignored, every access is a word
   octrx_pkg::octrx_phase_t   phase_r;
   octrx_pkg::octrx_phase_t   phase_nxt;
   logic [AW-1:0]             addr_r;
   logic [AW-1:0]             addr_nxt;
   logic                      req_take;

   assign req_take = hsel & htrans[1] & hready;

   always_comb begin
      phase_nxt = octrx_pkg::OCTRX_PH_IDLE;
      addr_nxt  = addr_r;
      if (req_take) begin
         addr_nxt  = haddr[AW-1:0];
         phase_nxt = hwrite ? octrx_pkg::OCTRX_PH_WRITE : octrx_pkg::OCTRX_PH_READ;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r <= octrx_pkg::OCTRX_PH_IDLE;
         addr_r  <= '0;
      end else begin
         phase_r <= phase_nxt;
         addr_r  <= addr_nxt;
      end
   end

   // Software-visible state
   logic [CW-1:0]             ctrl_r;
   logic [CW-1:0]             ctrl_nxt;
   logic                      a_flag_r;
   logic                      a_flag_nxt;
   logic                      b_flag_r;
   logic                      b_flag_nxt;
   logic [NW-1:0]             a_cnt_r;
   logic [NW-1:0]             a_cnt_nxt;
   logic [NW-1:0]             b_cnt_r;
   logic [NW-1:0]             b_cnt_nxt;
   logic                      wr_en;

   // Writes land at the end of their data phase; capture counts wrap at their width
   assign wr_en = (phase_r == octrx_pkg::OCTRX_PH_WRITE);

   always_comb begin
      ctrl_nxt   = ctrl_r;
      a_flag_nxt = a_flag_r;
      b_flag_nxt = b_flag_r;
      a_cnt_nxt  = a_cnt_r;
      b_cnt_nxt  = b_cnt_r;
      if (wr_en) begin
         unique case (addr_r)
            `OCTRX_CTRL_OFS: begin
               ctrl_nxt = hwdata[CW-1:0];
            end
            `OCTRX_STATUS_OFS: begin
               if (hwdata[`OCTRX_STAT_A_CAP_BIT]) begin
                  a_flag_nxt = 1'b0;
               end
               if (hwdata[`OCTRX_STAT_B_CAP_BIT]) begin
                  b_flag_nxt = 1'b0;
               end
            end
            `OCTRX_COUNT_OFS: begin
               a_cnt_nxt = '0;
               b_cnt_nxt = '0;
            end
            default: begin
            end
         endcase
      end
      // A capture in the clearing cycle keeps its flag and its count
      if (a_captured) begin
         a_flag_nxt = 1'b1;
         a_cnt_nxt  = NW'(a_cnt_nxt + 1'b1);
      end
      if (b_captured) begin
         b_flag_nxt = 1'b1;
         b_cnt_nxt  = NW'(b_cnt_nxt + 1'b1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r   <= CW'(`OCTRX_CTRL_RESET);
         a_flag_r <= 1'b0;
         b_flag_r <= 1'b0;
         a_cnt_r  <= '0;
         b_cnt_r  <= '0;
      end else begin
         ctrl_r   <= ctrl_nxt;
         a_flag_r <= a_flag_nxt;
         b_flag_r <= b_flag_nxt;
         a_cnt_r  <= a_cnt_nxt;
         b_cnt_r  <= b_cnt_nxt;
      end
   end

   // Port drivers follow the control value that takes effect this edge
   octrx_pkg::octrx_drive_t   drv_nxt;
   octrx_pkg::octrx_drive_t   drv_now;
   logic [WIDTH-1:0]          a_out_nxt;
   logic [WIDTH-1:0]          b_out_nxt;
   logic [WIDTH-1:0]          a_out_r;
   logic [WIDTH-1:0]          b_out_r;
   logic                      a_oe_r;
   logic                      b_oe_r;
   logic                      a_src_stored;
   logic                      b_src_stored;

   // Live data reaches the far port one hclk after it is sampled
   always_comb begin
      drv_nxt   = drive_decode(ctrl_nxt[`OCTRX_CTRL_OE_N_BIT], ctrl_nxt[`OCTRX_CTRL_DIR_BIT]);
      a_src_stored = ctrl_nxt[`OCTRX_CTRL_ASRC_BIT];
      b_src_stored = ctrl_nxt[`OCTRX_CTRL_BSRC_BIT];
      a_out_nxt = a_src_stored ? b_stored : b_bus_in;
      b_out_nxt = b_src_stored ? a_stored : a_bus_in;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_out_r <= '0;
         b_out_r <= '0;
         a_oe_r  <= 1'b0;
         b_oe_r  <= 1'b0;
      end else begin
         a_out_r <= a_out_nxt;
         b_out_r <= b_out_nxt;
         a_oe_r  <= drv_nxt.a_en;
         b_oe_r  <= drv_nxt.b_en;
      end
   end

   assign drv_now = drive_decode(ctrl_r[`OCTRX_CTRL_OE_N_BIT], ctrl_r[`OCTRX_CTRL_DIR_BIT]);

   // Read-back words, assembled once for the read mux
   logic [31:0]               status_word;
   logic [31:0]               pins_word;
   logic [31:0]               count_word;

   always_comb begin
      status_word                        = 32'h0000_0000;
      status_word[`OCTRX_STAT_A_CAP_BIT] = a_flag_nxt;
      status_word[`OCTRX_STAT_B_CAP_BIT] = b_flag_nxt;
      status_word[`OCTRX_STAT_A_OE_BIT]  = drv_now.a_en;
      status_word[`OCTRX_STAT_B_OE_BIT]  = drv_now.b_en;
      pins_word  = place(32'(a_bus_in), `OCTRX_PINS_A_LSB)
                 | place(32'(b_bus_in), `OCTRX_PINS_B_LSB);
      count_word = place(32'(a_cnt_nxt), `OCTRX_CNT_A_LSB)
                 | place(32'(b_cnt_nxt), `OCTRX_CNT_B_LSB);
   end

   // Read data is formed from next values so a read right after a write sees it, except the status enable bits, which come from ctrl_r
   logic [31:0]               rdata_nxt;
   logic [31:0]               rdata_r;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (req_take && !hwrite) begin
         unique case (haddr[AW-1:0])
            `OCTRX_CTRL_OFS: begin
               rdata_nxt = 32'(ctrl_nxt);
            end
            `OCTRX_STATUS_OFS: begin
               rdata_nxt = status_word;
            end
            `OCTRX_A_STORE_OFS: begin
               rdata_nxt = 32'(a_stored);
            end
            `OCTRX_B_STORE_OFS: begin
               rdata_nxt = 32'(b_stored);
            end
            `OCTRX_PINS_OFS: begin
               rdata_nxt = pins_word;
            end
            `OCTRX_COUNT_OFS: begin
               rdata_nxt = count_word;
            end
            default: begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Zero-wait slave: ready and OKAY are constant flops
   logic                      ready_r;
   logic                      resp_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_r <= 1'b1;
         resp_r  <= 1'b0;
      end else begin
         ready_r <= 1'b1;
         resp_r  <= 1'b0;
      end
   end

   assign hreadyout = ready_r;
   assign hresp     = resp_r;
   assign hrdata    = rdata_r;
   assign a_bus_out = a_out_r;
   assign a_bus_oe  = a_oe_r;
   assign b_bus_out = b_out_r;
   assign b_bus_oe  = b_oe_r;

endmodule : octrx_top

// File: test/octrx_far_side.sv
`timescale 1ns/1ns

module octrx_far_side #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] a_drive,
   input  wire logic [WIDTH-1:0] b_drive,
   input  wire logic [WIDTH-1:0] a_bus_out,
   input  wire logic             a_bus_oe,
   input  wire logic [WIDTH-1:0] b_bus_out,
   input  wire logic             b_bus_oe,
   output logic      [WIDTH-1:0] a_bus_in,
   output logic      [WIDTH-1:0] b_bus_in
);
   // Outside logic lets go of a bus while the block drives it
   assign a_bus_in = a_bus_oe ? a_bus_out : a_drive;
   assign b_bus_in = b_bus_oe ? b_bus_out : b_drive;
endmodule : octrx_far_side

// File: test/octrx_asserts.sv
`timescale 1ns/1ns
`include "octrx_cfg.svh"

module octrx_chk #(
   parameter int WIDTH = 8
) (
   input wire logic             hclk,
   input wire logic             hresetn,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [2:0]       hsize,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic             hreadyout,
   input wire logic             hresp,
   input wire logic [31:0]      hrdata,
   input wire logic             a_capture_clock,
   input wire logic             b_capture_clock,
   input wire logic [WIDTH-1:0] a_bus_in,
   input wire logic [WIDTH-1:0] a_bus_out,
   input wire logic             a_bus_oe,
   input wire logic [WIDTH-1:0] b_bus_in,
   input wire logic [WIDTH-1:0] b_bus_out,
   input wire logic             b_bus_oe
);
   logic             wp_r, wp_nxt, pa_r, pb_r;
   logic [3:0]       c_r, c_nxt;
   logic [WIDTH-1:0] sa_r, sa_nxt, sb_r, sb_nxt;

   // Shadow of the control word and of both storage registers
   always_comb begin
      wp_nxt = hsel && htrans[1] && hready && hwrite && haddr[7:0] == `OCTRX_CTRL_OFS;
      c_nxt = wp_r ? hwdata[3:0] : c_r;
      sa_nxt = (a_capture_clock && !pa_r) ? a_bus_in : sa_r;
      sb_nxt = (b_capture_clock && !pb_r) ? b_bus_in : sb_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r <= 1'b0;
         c_r <= `OCTRX_CTRL_RESET;
         pa_r <= 1'b0;
         pb_r <= 1'b0;
         sa_r <= `OCTRX_STORE_RESET;
         sb_r <= `OCTRX_STORE_RESET;
      end else begin
         wp_r <= wp_nxt;
         c_r <= c_nxt;
         pa_r <= a_capture_clock;
         pb_r <= b_capture_clock;
         sa_r <= sa_nxt;
         sb_r <= sb_nxt;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_NEVER_BOTH: assert property (!(a_bus_oe && b_bus_oe))
      else $error("both ports driven");
   AST_ISOLATE: assert property (c_r[0] |-> !a_bus_oe && !b_bus_oe)
      else $error("port driven while disabled");
   AST_A_OE: assert property (a_bus_oe == (!c_r[0] && !c_r[1]))
      else $error("A enable wrong");
   AST_B_OE: assert property (b_bus_oe == (!c_r[0] && c_r[1]))
      else $error("B enable wrong");
   AST_A_LIVE: assert property (a_bus_oe && !c_r[2] && $stable(c_r)
      |-> a_bus_out == $past(b_bus_in)) else $error("A live data wrong");
   AST_A_STORED: assert property (a_bus_oe && c_r[2] && $stable(c_r) && $stable(sb_r)
      |-> a_bus_out == sb_r) else $error("A stored data wrong");
   AST_B_LIVE: assert property (b_bus_oe && !c_r[3] && $stable(c_r)
      |-> b_bus_out == $past(a_bus_in)) else $error("B live data wrong");
   AST_B_STORED: assert property (b_bus_oe && c_r[3] && $stable(c_r) && $stable(sa_r)
      |-> b_bus_out == sa_r) else $error("B stored data wrong");
endmodule : octrx_chk

bind octrx_top octrx_chk #(.WIDTH(WIDTH)) octrx_chk_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .a_capture_clock(a_capture_clock), .b_capture_clock(b_capture_clock),
   .a_bus_in(a_bus_in), .a_bus_out(a_bus_out), .a_bus_oe(a_bus_oe),
   .b_bus_in(b_bus_in), .b_bus_out(b_bus_out), .b_bus_oe(b_bus_oe));

// File: test/tb_octal_registered_bus_transceiver.sv
`timescale 1ns/1ns
`include "octrx_cfg.svh"

module tb_octal_registered_bus_transceiver;
   localparam int W = 8;
   logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic          acc = 1'b0, bcc = 1'b0, hreadyout, hresp, aoe, boe;
   logic [1:0]    htrans = 2'h0;
   logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [W-1:0]  ain, aout, bin, bout, adrv = 8'h00, bdrv = 8'h00, sa, sb, aw, bw;
   logic [3:0]    c;
   int            failures = 0, num_checks = 0;
   int            na = 0, nb = 0;

   always #5 hclk = ~hclk;

   octrx_top #(.WIDTH(W)) octrx_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .a_capture_clock(acc), .b_capture_clock(bcc), .a_bus_in(ain), .a_bus_out(aout),
      .a_bus_oe(aoe), .b_bus_in(bin), .b_bus_out(bout), .b_bus_oe(boe));
   octrx_far_side #(.WIDTH(W)) octrx_far_side_inst (.a_drive(adrv), .b_drive(bdrv),
      .a_bus_out(aout), .a_bus_oe(aoe), .b_bus_out(bout), .b_bus_oe(boe),
      .a_bus_in(ain), .b_bus_in(bin));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // One single word transfer; entered just after a rising edge
   task ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, ad};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : ahb

   // Model of the pins: expected enables, driven values and wire levels
   task pins;
      logic ao, bo;
      repeat (3) @(posedge hclk);
      ao = !c[0] && !c[1];
      bo = !c[0] && c[1];
      aw = ao ? (c[2] ? sb : bdrv) : adrv;
      bw = bo ? (c[3] ? sa : adrv) : bdrv;
      check({31'h0, aoe}, {31'h0, ao});
      check({31'h0, boe}, {31'h0, bo});
      if (ao) check({24'h0, aout}, {24'h0, aw});
      if (bo) check({24'h0, bout}, {24'h0, bw});
   endtask : pins

   task cap(input logic ca, input logic cb);
      acc <= ca;
      bcc <= cb;
      @(posedge hclk);
      acc <= 1'b0;
      bcc <= 1'b0;
      @(posedge hclk);
      if (ca) sa = aw;
      if (cb) sb = bw;
      na += int'(ca);
      nb += int'(cb);
   endtask : cap

   initial begin
      void'($urandom(32'h7415));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      c = 4'h1;
      adrv <= W'($urandom);
      bdrv <= W'($urandom);
      pins;
      cap(1'b1, 1'b1);
      for (int i = 0; i < 16; i++) begin
         c = i[3:0];
         ahb(1'b1, `OCTRX_CTRL_OFS, 32'(i));
         adrv <= W'($urandom);
         bdrv <= W'($urandom);
         pins;
         cap(i != 6, i != 9);
         ahb(1'b0, `OCTRX_A_STORE_OFS, 32'h0);
         check(rd, {24'h0, sa});
         ahb(1'b0, `OCTRX_B_STORE_OFS, 32'h0);
         check(rd, {24'h0, sb});
         adrv <= ~adrv;
         bdrv <= ~bdrv;
         pins;
         ahb(1'b0, `OCTRX_A_STORE_OFS, 32'h0);
         check(rd, {24'h0, sa});
      end
      c = 4'h2;
      ahb(1'b1, `OCTRX_CTRL_OFS, 32'h2);
      pins;
      ahb(1'b0, `OCTRX_STATUS_OFS, 32'h0);
      check(rd, 32'hb);
      ahb(1'b1, `OCTRX_STATUS_OFS, 32'h1);
      ahb(1'b0, `OCTRX_STATUS_OFS, 32'h0);
      check(rd, 32'ha);
      ahb(1'b0, `OCTRX_PINS_OFS, 32'h0);
      check(rd, {16'h0, bw, aw});
      ahb(1'b0, `OCTRX_COUNT_OFS, 32'h0);
      check(rd, {16'h0, nb[7:0], na[7:0]});
      ahb(1'b1, `OCTRX_COUNT_OFS, 32'h0);
      cap(1'b1, 1'b0);
      ahb(1'b0, `OCTRX_COUNT_OFS, 32'h0);
      check(rd, 32'h1);
      ahb(1'b0, `OCTRX_A_STORE_OFS, 32'h0);
      check(rd, {24'h0, sa});
      ahb(1'b0, 8'h18, 32'h0);
      check(rd, 32'h0);
      complete_run;
   end

   initial begin
      repeat (5000) @(posedge hclk);
      failures++;
      complete_run;
   end
endmodule : tb_octal_registered_bus_transceiver
